/* File: hdl/acs_defs.vh */
// Constants for the converter control and status front end.
// Assumes a 32-bit AHB-Lite slave port and one system clock.
//
// What this block does
// - Writing start one with power one in the same byte begins a conversion unless one is still running
// - Start bit reads one while converting
// - Writing start zero changes nothing
// - Reference bit selects internal or external reference
// - Power bit enables or disables converter
// - Three-bit field selects analog input n
// - Read-only eight-bit raw high register
// - Raw register follows core working value
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ==========================================================
// Register indices; byte address is four times the index
`define ACS_IDX_CTRL 12'hF70
`define ACS_IDX_RAW 12'hF71
`define ACS_IDX_LSB 2

// ==========================================================
// Control register fields
`define ACS_BIT_START 7
`define ACS_BIT_RSV_HI 6
`define ACS_BIT_REF 5
`define ACS_BIT_PWR 4
`define ACS_BIT_RSV_LO 3
`define ACS_CH_HI 2
`define ACS_CH_LO 0
`define ACS_CTRL_RESET 8'h00
`define ACS_RAW_RESET 8'h00

// ==========================================================
// AHB-Lite encodings
`define ACS_HTRANS_NONSEQ 2'h2
`define ACS_HTRANS_SEQ 2'h3
`define ACS_HRESP_OKAY 1'h0

`endif

/* File: hdl/acs_top.v */
// Converter control and status registers behind an AHB-Lite slave.
// Assumes a conversion core that takes a start pulse, answers with a
// one-cycle done pulse and presents its working value continuously.
`timescale 1ns/1ps
`include "acs_defs.vh"

module acs_top #(
  parameter ADDR_W = 32
) (
  input wire CORE_CLK_I,
  input wire RST_B_I,
  input wire HSEL_I,
  input wire [ADDR_W-1:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output wire HREADYOUT_O,
  output wire HRESP_O,
  input wire CONV_DONE_I,
  input wire [7:0] RAW_RESULT_HIGH_I,
  output reg CONV_START_O,
  output wire CONV_BUSY_O,
  output wire [2:0] INPUT_CHANNEL_SELECT_O,
  output wire INTERNAL_REFERENCE_ON_O,
  output wire CONVERTER_POWER_ON_O
);

  // ==========================================================
  // Local sizes, state codes and register selects
  localparam REG_W = 8;
  localparam DATA_W = 32;
  localparam PAD_W = DATA_W - REG_W;
  localparam IDX_W = 12;
  localparam CH_W = `ACS_CH_HI - `ACS_CH_LO + 1;
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  localparam SEL_NONE = 2'b00;
  localparam SEL_CTRL = 2'b01;
  localparam SEL_RAW = 2'b10;

  // ==========================================================
  // Helper functions
  // Byte address of a register index
  function [ADDR_W-1:0] idx_to_addr;
    input [IDX_W-1:0] idx;
    begin
      idx_to_addr = {{(ADDR_W-IDX_W){1'b0}}, idx} << `ACS_IDX_LSB;
    end
  endfunction

  // Address phase that starts a transfer
  function is_transfer;
    input sel;
    input ready;
    input [1:0] trans;
    begin
      is_transfer = sel & ready & ((trans == `ACS_HTRANS_NONSEQ)
        | (trans == `ACS_HTRANS_SEQ));
    end
  endfunction

  // Which register an address names
  function [1:0] reg_select;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == idx_to_addr(`ACS_IDX_CTRL)) begin
        reg_select = SEL_CTRL;
      end else if (addr == idx_to_addr(`ACS_IDX_RAW)) begin
        reg_select = SEL_RAW;
      end else begin
        reg_select = SEL_NONE;
      end
    end
  endfunction

  // Zero-extend a register byte to a bus word
  function [DATA_W-1:0] widen;
    input [REG_W-1:0] value;
    begin
      widen = {{PAD_W{1'b0}}, value};
    end
  endfunction

  // Start/busy bit of a control byte
  function start_of;
    input [REG_W-1:0] value;
    begin
      start_of = value[`ACS_BIT_START];
    end
  endfunction

  // Channel select field of a control byte
  function [CH_W-1:0] channel_of;
    input [REG_W-1:0] value;
    begin
      channel_of = value[`ACS_CH_HI:`ACS_CH_LO];
    end
  endfunction

  // Reference enable bit of a control byte
  function reference_of;
    input [REG_W-1:0] value;
    begin
      reference_of = value[`ACS_BIT_REF];
    end
  endfunction

  // Power enable bit of a control byte
  function power_of;
    input [REG_W-1:0] value;
    begin
      power_of = value[`ACS_BIT_PWR];
    end
  endfunction

  // Writable fields of the control byte; the start bit is not one
  function [REG_W-1:0] merge_fields;
    input [REG_W-1:0] old_value;
    input [REG_W-1:0] wdata;
    reg [REG_W-1:0] result;
    begin
      result = old_value;
      result[`ACS_BIT_RSV_HI] = wdata[`ACS_BIT_RSV_HI];
      result[`ACS_BIT_REF] = wdata[`ACS_BIT_REF];
      result[`ACS_BIT_PWR] = wdata[`ACS_BIT_PWR];
      result[`ACS_BIT_RSV_LO] = wdata[`ACS_BIT_RSV_LO];
      result[`ACS_CH_HI:`ACS_CH_LO] = wdata[`ACS_CH_HI:`ACS_CH_LO];
      merge_fields = result;
    end
  endfunction

  // Bus word for a selected register
  function [DATA_W-1:0] read_word;
    input [1:0] sel;
    input [REG_W-1:0] ctrl_value;
    input [REG_W-1:0] raw_value;
    begin
      case (sel)
        SEL_CTRL: begin
          read_word = widen(ctrl_value);
        end
        SEL_RAW: begin
          read_word = widen(raw_value);
        end
        default: begin
          read_word = {DATA_W{1'b0}};
        end
      endcase
    end
  endfunction

  // ==========================================================
  // Address phase decode
  wire access;
  wire rd_access;
  wire wr_access;
  wire [1:0] addr_sel;

  assign access = is_transfer(HSEL_I, HREADY_I, HTRANS_I);
  assign rd_access = access & ~HWRITE_I;
  assign wr_access = access & HWRITE_I;
  assign addr_sel = reg_select(HADDR_I);

  // Zero wait state, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = `ACS_HRESP_OKAY;

  // ==========================================================
  // Data phase flag for a control write
  reg wr_ctrl;
  reg next_wr_ctrl;

  always @* begin
    next_wr_ctrl = 1'b0;
    if (wr_access && (addr_sel == SEL_CTRL)) begin
      next_wr_ctrl = 1'b1;
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_ctrl <= 1'b0;
    end else begin
      wr_ctrl <= next_wr_ctrl;
    end
  end

  // ==========================================================
  // Write data decode
  wire [REG_W-1:0] wbyte;
  wire start_req;
  wire power_req;
  wire go;

  assign wbyte = HWDATA_I[REG_W-1:0];
  assign start_req = wr_ctrl & start_of(wbyte);
  assign power_req = power_of(wbyte);
  // A start without power in the same byte is ignored
  assign go = start_req & power_req;

  // ==========================================================
  // Conversion sequencer; the state is the start/busy bit
  reg state;
  reg next_state;
  reg next_start;

  // Done and a fresh start in one data phase: the start wins
  always @* begin
    next_state = state;
    next_start = 1'b0;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_state = ST_BUSY;
          next_start = 1'b1;
        end
      end
      ST_BUSY: begin
        // Writes during a conversion neither abort nor restart it
        if (CONV_DONE_I) begin
          next_state = ST_IDLE;
          if (go) begin
            next_state = ST_BUSY;
            next_start = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= ST_IDLE;
      CONV_START_O <= 1'b0;
    end else begin
      state <= next_state;
      CONV_START_O <= next_start;
    end
  end

  // ==========================================================
  // Control register fields
  reg [REG_W-1:0] fields;
  reg [REG_W-1:0] next_fields;

  // Reserved bits stored as written; software keeps them zero
  always @* begin
    next_fields = fields;
    if (wr_ctrl) begin
      next_fields = merge_fields(fields, wbyte);
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fields <= `ACS_CTRL_RESET;
    end else begin
      fields <= next_fields;
    end
  end

  wire [REG_W-1:0] ctrl_now;
  wire [REG_W-1:0] ctrl_next;

  assign ctrl_now = {state, fields[REG_W-2:0]};
  assign ctrl_next = {next_state, next_fields[REG_W-2:0]};

  assign CONV_BUSY_O = state;
  assign INPUT_CHANNEL_SELECT_O = channel_of(ctrl_now);
  assign INTERNAL_REFERENCE_ON_O = reference_of(ctrl_now);
  assign CONVERTER_POWER_ON_O = power_of(ctrl_now);

  // ==========================================================
  // Raw working value, for test use only
  reg [REG_W-1:0] raw_high;

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      raw_high <= `ACS_RAW_RESET;
    end else begin
      raw_high <= RAW_RESULT_HIGH_I;
    end
  end

  // ==========================================================
  // Read data, captured at the address phase; control from the next state, raw from its current register
  reg [DATA_W-1:0] next_rdata;

  always @* begin
    next_rdata = HRDATA_O;
    if (rd_access) begin
      next_rdata = read_word(addr_sel, ctrl_next, raw_high);
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HRDATA_O <= {DATA_W{1'b0}};
    end else begin
      HRDATA_O <= next_rdata;
    end
  end

endmodule

/* File: test/acs_chk_asserts.sv */
// Checker on the acs_top ports, bound below.
// Assumes hready is always high and the slave is always selected.
`timescale 1ns/1ps
module acs_chk(input CORE_CLK_I,RST_B_I,HSEL_I,HWRITE_I,CONV_DONE_I,CONV_START_O,
  CONV_BUSY_O,INTERNAL_REFERENCE_ON_O,CONVERTER_POWER_ON_O,input [1:0] HTRANS_I,
  input [2:0] INPUT_CHANNEL_SELECT_O,input [31:0] HADDR_I,HWDATA_I);
  logic w;
  wire b=CONV_BUSY_O,p=CONV_START_O,d=CONV_DONE_I,s=w&&HWDATA_I[7];
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Control write in data phase
  always @(posedge CORE_CLK_I or negedge RST_B_I)
    w<=RST_B_I&&HSEL_I&&HTRANS_I[1]&&HWRITE_I&&HADDR_I==32'h3DC0;
  go_pulse_a: assert property(s&&HWDATA_I[4]&&(!b||d)|=>p)else $error("go");
  go_cause_a: assert property(p|->$past(s))else $error("cause");
  go_once_a: assert property(p|=>!p)else $error("once");
  busy_set_a: assert property(p|->b)else $error("set");
  busy_rise_a: assert property($rose(b)|->p)else $error("rise");
  busy_hold_a: assert property(b&&!d|=>b)else $error("hold");
  busy_end_a: assert property(b&&d&&!s|=>!b)else $error("end");
  field_load_a: assert property(w|=>{INTERNAL_REFERENCE_ON_O,CONVERTER_POWER_ON_O,
    INPUT_CHANNEL_SELECT_O}==$past({HWDATA_I[5:4],HWDATA_I[2:0]}))else $error("load");
endmodule
bind acs_top acs_chk u_acs_chk(.*);

/* File: test/acs_core_model.sv */
// Conversion core stand-in: done pulse ten cycles after start.
// Assumes a one-cycle start pulse from the block.
`timescale 1ns/1ps
module acs_core_model(input CORE_CLK_I,RST_B_I,CONV_START_O,
  output logic CONV_DONE_I,output logic [7:0] RAW_RESULT_HIGH_I);
  logic [3:0] n;
  always @(posedge CORE_CLK_I or negedge RST_B_I)
    if (!RST_B_I) {n,CONV_DONE_I,RAW_RESULT_HIGH_I}<=13'h0;
    else begin
      CONV_DONE_I<=n==4'h1;
      n<=CONV_START_O?4'h9:n-{3'h0,n!=4'h0};
      if (n!=4'h0) RAW_RESULT_HIGH_I<=RAW_RESULT_HIGH_I+8'h11;
    end
endmodule

/* File: test/acs_top_bench.sv */
// Bench for acs_top beside the core stand-in.
// Assumes hready is fed back from the slave.
`timescale 1ns/1ps
module acs_top_bench;
  logic CORE_CLK_I=0,RST_B_I=0,HSEL_I=1,HWRITE_I=0;
  logic [1:0] HTRANS_I=0;
  logic [2:0] HSIZE_I=3'h2;
  logic [31:0] HADDR_I=0,HWDATA_I=0;
  wire [31:0] HRDATA_O;
  wire [7:0] RAW_RESULT_HIGH_I;
  wire [2:0] INPUT_CHANNEL_SELECT_O;
  wire HREADYOUT_O,HRESP_O,CONV_DONE_I,CONV_START_O,CONV_BUSY_O,CONVERTER_POWER_ON_O;
  wire INTERNAL_REFERENCE_ON_O,HREADY_I=HREADYOUT_O;
  int n_fail=0,n_checks=0,k;
  acs_top u_acs_top(.*);
  acs_core_model u_acs_core_model(.*);
  always #12.5 CORE_CLK_I=~CORE_CLK_I;
  task finish_test;
    $display("checks %0d fails %0d",n_checks,n_fail);
    if (n_fail==0&&n_checks>0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [31:0] g,e);
    n_checks++;
    if (g!==e) begin n_fail++; $display("wrong value %0t %h %h",$time,g,e); end
  endtask
  task wt;
    for (k=0;k<50;k++) begin @(posedge CORE_CLK_I); if (HREADY_I) return; end
    n_fail++; finish_test;
  endtask
  task bus(input [31:0] a,d,input w,input [31:0] e);
    @(posedge CORE_CLK_I); HADDR_I<=a; HWRITE_I<=w; HTRANS_I<=2'h2; wt;
    HTRANS_I<=2'h0; HWDATA_I<=d; wt; #1;
    if (!w) chk(HRDATA_O,e);
  endtask
  task s_fields;
    bus(32'h3DC0,0,0,0);
    bus(32'h3DC8,0,0,0);
    for (int c=0;c<8;c++) begin
      bus(32'h3DC0,{c[0],5'h10}|c,1,0);
      bus(32'h3DC0,0,0,{c[0],5'h10}|c);
    end
  endtask
  task s_conv;
    bus(32'h3DC0,32'h80,1,0); chk(CONV_BUSY_O,0);
    bus(32'h3DC0,32'hB5,1,0); chk({CONV_START_O,CONV_BUSY_O},3);
    bus(32'h3DC0,32'h13,1,0); chk({CONV_START_O,CONV_BUSY_O},1);
    chk({INTERNAL_REFERENCE_ON_O,CONVERTER_POWER_ON_O,INPUT_CHANNEL_SELECT_O},5'h0B);
    bus(32'h3DC0,32'h93,1,0); chk({CONV_START_O,CONV_BUSY_O},1);
    for (k=0;k<50&&CONV_BUSY_O;k++) @(posedge CORE_CLK_I);
    if (CONV_BUSY_O!==1'b0) begin n_fail++; finish_test; end
    bus(32'h3DC0,0,0,32'h13);
    bus(32'h3DC4,0,0,32'h99);
  endtask
  initial begin
    repeat (4) @(posedge CORE_CLK_I);
    RST_B_I<=1;
    s_fields;
    s_conv;
    finish_test;
  end
endmodule
